// file: include/host_port_pkg.sv
// Purpose: Shared constants, carriers and state for the strapped host access port.
// Assumes: One 20 MHz clock; host pins are asynchronous and pass a two-stage synchroniser.

package host_port_pkg;

   localparam int ADDR_W = 11;
   localparam int DATA_W = 16;

   localparam logic [1:0] MODE_STROBE_PAIR   = 2'h0;
   localparam logic [1:0] MODE_DATA_STROBE   = 2'h1;
   localparam logic [1:0] MODE_SERIAL_PERIPH = 2'h2;
   localparam logic [1:0] MODE_SERIAL_SELECT = 2'h3;

   // Strap field positions on the host data and address pins
   localparam int STRAP_M_LSB   = 11;
   localparam int STRAP_M_W     = 5;
   localparam int STRAP_N_LSB   = 5;
   localparam int STRAP_N_W     = 6;
   localparam int SRC_STRAP_W   = 6;
   localparam logic [1:0] SRC_ADDR_LSBS = 2'h2;

   // Byte lane enables toward the register file
   localparam logic [1:0] LANES_NONE = 2'h0;
   localparam logic [1:0] LANES_LOW  = 2'h1;
   localparam logic [1:0] LANES_HIGH = 2'h2;
   localparam logic [1:0] LANES_WORD = 2'h3;

   // Timing
   localparam int CLK_MHZ          = 20;
   localparam int READY_HOLD_NS    = 50;
   localparam int READY_HOLD_RAW   = (READY_HOLD_NS * CLK_MHZ + 999) / 1000;
   localparam int READY_HOLD_CYC   = (READY_HOLD_RAW < 1) ? 1 : READY_HOLD_RAW;
   localparam int STRAP_SETTLE_CYC = 2;

   typedef struct packed {
      logic              selectN;
      logic              readN;
      logic              writeN;
      logic              dataStrobeN;
      logic              readNotWrite;
      logic              addrLatchEn;
      logic              highByteEnableN;
      logic              lowByteEnableN;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] data;
      logic [1:0]        modeStrap;
   } hostPins_s;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wrData;
      logic [1:0]        byteEn;
      logic              wr;
      logic              rd;
   } regReq_s;

   typedef enum logic [3:0] {
      ST_STRAP,
      ST_IDLE,
      ST_RD_FETCH,
      ST_RD_SHOW,
      ST_RD_DONE,
      ST_RD_HOLD,
      ST_WR_WAIT,
      ST_WR_DONE,
      ST_ACK_WAIT
   } access_e;

   typedef struct packed {
      access_e              fsm;
      logic [1:0]           strapCnt;
      logic                 strapDone;
      logic [1:0]           mode;
      logic [7:0]           srcAddr;
      logic [STRAP_M_W-1:0] strapM;
      logic [STRAP_N_W-1:0] strapN;
      logic [STRAP_M_W-1:0] pllM;
      logic [STRAP_N_W-1:0] pllN;
      logic                 aleLast;
      logic                 muxBus;
      logic [ADDR_W-1:0]    latchedAddr;
      logic [1:0]           lanes;
      logic                 oddByte;
      logic [2:0]           holdCnt;
      logic                 ready;
      logic                 ackN;
      logic [DATA_W-1:0]    dataOut;
      logic [1:0]           dataOe;
      regReq_s              req;
   } portState_s;

   localparam portState_s PORT_RESET = '{
      fsm:         ST_STRAP,
      strapCnt:    2'h0,
      strapDone:   1'b0,
      mode:        MODE_STROBE_PAIR,
      srcAddr:     8'h00,
      strapM:      '0,
      strapN:      '0,
      pllM:        '0,
      pllN:        '0,
      aleLast:     1'b0,
      muxBus:      1'b0,
      latchedAddr: '0,
      lanes:       LANES_NONE,
      oddByte:     1'b0,
      holdCnt:     3'h0,
      ready:       1'b1,
      ackN:        1'b1,
      dataOut:     16'h0000,
      dataOe:      2'h0,
      req:         '0
   };

endpackage

// file: rtl/pin_sync.sv
// Purpose: Two-stage synchroniser for a bundle of asynchronous levels.
// Assumes: Reset value of both stages is zero.
// Notes:   The first stage feeds only the second stage.
`timescale 1ns/100ps
`default_nettype none

module pin_sync #(
   parameter int WIDTH = 1
) (
   input  wire logic             clk,
   input  wire logic             rst_n,
   input  wire logic [WIDTH-1:0] d,
   output logic      [WIDTH-1:0] q
);

   logic [WIDTH-1:0] meta_q;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_q <= '0;
         q      <= '0;
      end else begin
         meta_q <= d;
         q      <= meta_q;
      end
   end

endmodule

`default_nettype wire

// file: rtl/async_host_port_strapping.sv
// Purpose: Strapped host interface selection and asynchronous parallel register port.
// Assumes: Host pins are asynchronous; register file answers a read in the next cycle.
// Notes:   Handshake outputs follow the synchronised strobes, so they lag pins by at least 2-3 cycles.
`timescale 1ns/100ps
`default_nettype none

module async_host_port_strapping (
   input  wire logic                           clk,
   input  wire logic                           arst_n,
   input  wire logic [1:0]                     host_mode_strap,
   input  wire logic                           selectN,
   input  wire logic                           readN,
   input  wire logic                           writeN,
   input  wire logic                           dataStrobeN,
   input  wire logic                           readNotWrite,
   input  wire logic                           addrLatchEn,
   input  wire logic                           high_byte_enable_n,
   input  wire logic                           low_byte_enable_n,
   input  wire logic [host_port_pkg::ADDR_W-1:0] hostAddr,
   input  wire logic [host_port_pkg::DATA_W-1:0] hostDataIn,
   output logic      [host_port_pkg::DATA_W-1:0] hostDataOut,
   output logic      [host_port_pkg::DATA_W-1:0] hostDataOe,
   output logic                                ready,
   output logic                                transfer_acknowledge_n,
   input  wire logic                           busWide16,
   input  wire logic [host_port_pkg::STRAP_M_W-1:0] pll_div_m_reg,
   input  wire logic [host_port_pkg::STRAP_N_W-1:0] pll_div_n_reg,
   output logic      [host_port_pkg::STRAP_M_W-1:0] pllDivM,
   output logic      [host_port_pkg::STRAP_N_W-1:0] pllDivN,
   output logic      [1:0]                     hostMode,
   output logic                                hostModeValid,
   output logic      [7:0]                     serialSrcAddr,
   output logic      [host_port_pkg::ADDR_W-1:0] regAddr,
   output logic      [host_port_pkg::DATA_W-1:0] regWrData,
   output logic      [1:0]                     regByteEn,
   output logic                                regWr,
   output logic                                regRd,
   input  wire logic [host_port_pkg::DATA_W-1:0] regRdData
);

   localparam int PIN_W = $bits(host_port_pkg::hostPins_s);

   logic                       rstN;
   host_port_pkg::hostPins_s   rawPins;
   host_port_pkg::hostPins_s   pins;
   host_port_pkg::portState_s  s_q;
   host_port_pkg::portState_s  s_d;

   // Decoded view of the current synchronised pins
   logic                              stylePair;
   logic                              styleStrobe;
   logic                              portSel;
   logic                              rdActive;
   logic                              wrActive;
   logic                              rdReleased;
   logic                              wrReleased;
   logic [host_port_pkg::ADDR_W-1:0]  accAddr;
   logic                              byteEnN;
   logic [1:0]                        laneSel;
   logic                              laneSwap;
   logic [host_port_pkg::DATA_W-1:0]  pinToReg;
   logic [host_port_pkg::DATA_W-1:0]  regToPin;
   logic [1:0]                        pinLanes;

   // Reset release is synchronised; assertion stays asynchronous
   pin_sync #(
      .WIDTH (1)
   ) u_rst_sync (
      .clk   (clk),
      .rst_n (arst_n),
      .d     (1'b1),
      .q     (rstN)
   );

   assign rawPins.selectN         = selectN;
   assign rawPins.readN           = readN;
   assign rawPins.writeN          = writeN;
   assign rawPins.dataStrobeN     = dataStrobeN;
   assign rawPins.readNotWrite    = readNotWrite;
   assign rawPins.addrLatchEn     = addrLatchEn;
   assign rawPins.highByteEnableN = high_byte_enable_n;
   assign rawPins.lowByteEnableN  = low_byte_enable_n;
   assign rawPins.addr            = hostAddr;
   assign rawPins.data            = hostDataIn;
   assign rawPins.modeStrap       = host_mode_strap;

   // Every host pin, straps included, crosses through two flops
   pin_sync #(
      .WIDTH (PIN_W)
   ) u_pin_sync (
      .clk   (clk),
      .rst_n (rstN),
      .d     (rawPins),
      .q     (pins)
   );

   always_comb begin
      stylePair   = s_q.strapDone && (s_q.mode == host_port_pkg::MODE_STROBE_PAIR);
      styleStrobe = s_q.strapDone && (s_q.mode == host_port_pkg::MODE_DATA_STROBE);
      portSel     = !pins.selectN && (stylePair || styleStrobe);
      rdActive    = stylePair ? !pins.readN : (!pins.dataStrobeN && pins.readNotWrite);
      wrActive    = stylePair ? !pins.writeN : (!pins.dataStrobeN && !pins.readNotWrite);
      rdReleased  = stylePair ? pins.readN : pins.dataStrobeN;
      wrReleased  = stylePair ? pins.writeN : pins.dataStrobeN;
      // Multiplexed bus only exists in strobe-pair style
      accAddr     = (s_q.muxBus && stylePair) ? s_q.latchedAddr : pins.addr;
      byteEnN     = stylePair ? pins.highByteEnableN : pins.lowByteEnableN;
      if (!busWide16) begin
         laneSel = accAddr[0] ? host_port_pkg::LANES_HIGH : host_port_pkg::LANES_LOW;
      end else begin
         case ({byteEnN, accAddr[0]})
            2'b00:   laneSel = host_port_pkg::LANES_WORD;
            2'b01:   laneSel = host_port_pkg::LANES_HIGH;
            2'b10:   laneSel = host_port_pkg::LANES_LOW;
            default: laneSel = host_port_pkg::LANES_NONE;
         endcase
      end
      // On a 16-bit bus, data-strobe style carries the even byte on the upper pins
      laneSwap = busWide16 && styleStrobe;
      if (!busWide16) begin
         pinToReg = {pins.data[7:0], pins.data[7:0]};
         regToPin = {8'h00, s_q.oddByte ? regRdData[15:8] : regRdData[7:0]};
         pinLanes = (s_q.lanes == host_port_pkg::LANES_NONE) ? 2'h0 : 2'h1;
      end else if (laneSwap) begin
         pinToReg = {pins.data[7:0], pins.data[15:8]};
         regToPin = {regRdData[7:0], regRdData[15:8]};
         pinLanes = {s_q.lanes[0], s_q.lanes[1]};
      end else begin
         pinToReg = pins.data;
         regToPin = regRdData;
         pinLanes = s_q.lanes;
      end
   end

   always_comb begin
      s_d        = s_q;
      s_d.req.wr = 1'b0;
      s_d.req.rd = 1'b0;

      // A moving latch enable marks a multiplexed bus; address taken on its falling edge
      s_d.aleLast = pins.addrLatchEn;
      if (stylePair && (pins.addrLatchEn != s_q.aleLast)) begin
         s_d.muxBus = 1'b1;
      end
      if (stylePair && s_q.aleLast && !pins.addrLatchEn) begin
         s_d.latchedAddr = pins.data[host_port_pkg::ADDR_W-1:0];
      end

      // Serial modes take the strapped dividers, parallel modes the register fields
      if (s_q.strapDone && s_q.mode[1]) begin
         s_d.pllM = s_q.strapM;
         s_d.pllN = s_q.strapN;
      end else begin
         s_d.pllM = pll_div_m_reg;
         s_d.pllN = pll_div_n_reg;
      end

      case (s_q.fsm)
         host_port_pkg::ST_STRAP: begin
            // Wait for the synchroniser to fill before trusting strapped levels
            s_d.strapCnt = s_q.strapCnt + 2'h1;
            if (s_q.strapCnt == 2'(host_port_pkg::STRAP_SETTLE_CYC)) begin
               s_d.mode      = pins.modeStrap;
               s_d.strapDone = 1'b1;
               if (pins.modeStrap == host_port_pkg::MODE_SERIAL_SELECT) begin
                  s_d.srcAddr = {pins.addr[host_port_pkg::SRC_STRAP_W-1:0],
                                 host_port_pkg::SRC_ADDR_LSBS};
               end
               if (pins.modeStrap[1]) begin
                  s_d.strapM = pins.data[host_port_pkg::STRAP_M_LSB +: host_port_pkg::STRAP_M_W];
                  s_d.strapN = pins.data[host_port_pkg::STRAP_N_LSB +: host_port_pkg::STRAP_N_W];
               end
               s_d.fsm = host_port_pkg::ST_IDLE;
            end
         end

         host_port_pkg::ST_IDLE: begin
            // Each access is decoded afresh, so byte and word accesses mix freely
            if (portSel && rdActive) begin
               s_d.lanes      = laneSel;
               s_d.oddByte    = accAddr[0];
               s_d.req.addr   = accAddr;
               s_d.req.byteEn = laneSel;
               s_d.req.rd     = (laneSel != host_port_pkg::LANES_NONE);
               s_d.fsm        = host_port_pkg::ST_RD_FETCH;
            end else if (portSel && wrActive) begin
               s_d.lanes      = laneSel;
               s_d.oddByte    = accAddr[0];
               s_d.req.addr   = accAddr;
               s_d.req.byteEn = laneSel;
               if (stylePair) begin
                  s_d.ready = 1'b0;
                  s_d.fsm   = host_port_pkg::ST_WR_WAIT;
               end else begin
                  // Data-strobe write data is set up before the strobe falls
                  s_d.req.wrData = pinToReg;
                  s_d.req.wr     = (laneSel != host_port_pkg::LANES_NONE);
                  s_d.fsm        = host_port_pkg::ST_ACK_WAIT;
               end
            end
         end

         host_port_pkg::ST_RD_FETCH: begin
            s_d.fsm = host_port_pkg::ST_RD_SHOW;
         end

         host_port_pkg::ST_RD_SHOW: begin
            s_d.dataOut = regToPin;
            s_d.dataOe  = pinLanes;
            s_d.fsm     = host_port_pkg::ST_RD_DONE;
         end

         host_port_pkg::ST_RD_DONE: begin
            // Data pins have stood for a cycle before the handshake moves
            if (stylePair) begin
               s_d.ready = 1'b0;
            end else begin
               s_d.ackN = 1'b0;
            end
            if (rdReleased) begin
               s_d.dataOe = 2'h0;
               if (stylePair) begin
                  s_d.holdCnt = 3'(host_port_pkg::READY_HOLD_CYC);
                  s_d.fsm     = host_port_pkg::ST_RD_HOLD;
               end else begin
                  s_d.ackN = 1'b1;
                  s_d.fsm  = host_port_pkg::ST_IDLE;
               end
            end
         end

         host_port_pkg::ST_RD_HOLD: begin
            if (s_q.holdCnt <= 3'h1) begin
               s_d.ready = 1'b1;
               s_d.fsm   = host_port_pkg::ST_IDLE;
            end else begin
               s_d.holdCnt = s_q.holdCnt - 3'h1;
            end
         end

         host_port_pkg::ST_WR_WAIT: begin
            // Strobe-pair data is valid at the rising write strobe
            if (wrReleased) begin
               s_d.req.wrData = pinToReg;
               s_d.req.wr     = (s_q.lanes != host_port_pkg::LANES_NONE);
               s_d.fsm        = host_port_pkg::ST_WR_DONE;
            end
         end

         host_port_pkg::ST_WR_DONE: begin
            // The store happens on this cycle's edge, so ready rises right after it
            s_d.ready = 1'b1;
            s_d.fsm   = host_port_pkg::ST_IDLE;
         end

         host_port_pkg::ST_ACK_WAIT: begin
            s_d.ackN = 1'b0;
            if (wrReleased) begin
               s_d.ackN = 1'b1;
               s_d.fsm  = host_port_pkg::ST_IDLE;
            end
         end

         default: begin
            s_d = host_port_pkg::PORT_RESET;
         end
      endcase
   end

   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         s_q <= host_port_pkg::PORT_RESET;
      end else begin
         s_q <= s_d;
      end
   end

   assign hostDataOut            = s_q.dataOut;
   assign hostDataOe             = {{8{s_q.dataOe[1]}}, {8{s_q.dataOe[0]}}};
   assign ready                  = s_q.ready;
   assign transfer_acknowledge_n = s_q.ackN;
   assign pllDivM                = s_q.pllM;
   assign pllDivN                = s_q.pllN;
   assign hostMode               = s_q.mode;
   assign hostModeValid          = s_q.strapDone;
   assign serialSrcAddr          = s_q.srcAddr;
   assign regAddr                = s_q.req.addr;
   assign regWrData              = s_q.req.wrData;
   assign regByteEn              = s_q.req.byteEn;
   assign regWr                  = s_q.req.wr;
   assign regRd                  = s_q.req.rd;

endmodule

`default_nettype wire

// file: bench/async_host_port_monitor.sv
// Purpose: Pin-level checks of handshakes, lanes and strapped values.
// Assumes: Bound to async_host_port_strapping; straps captured once per reset.
// Notes:   Mode checks key off the captured mode, not the strap pins.
`timescale 1ns/100ps
`default_nettype none
module async_host_port_monitor (
   input wire logic        clk,
   input wire logic        arst_n,
   input wire logic [15:0] hostDataOe,
   input wire logic        ready,
   input wire logic        transfer_acknowledge_n,
   input wire logic [4:0]  pll_div_m_reg,
   input wire logic [5:0]  pll_div_n_reg,
   input wire logic [4:0]  pllDivM,
   input wire logic [5:0]  pllDivN,
   input wire logic [1:0]  hostMode,
   input wire logic        hostModeValid,
   input wire logic [7:0]  serialSrcAddr,
   input wire logic [1:0]  regByteEn,
   input wire logic        regWr,
   input wire logic        regRd
);
   logic sp;
   logic ds;
   assign sp = hostModeValid && hostMode == 2'h0;
   assign ds = hostModeValid && hostMode == 2'h1;
   default clocking @(posedge clk); endclocking
   default disable iff (!arst_n);
   AST_ONE_STROBE: assert property (!(regRd && regWr))
      else $error("register read and write together");
   AST_WR_DONE: assert property (sp && regWr |-> !ready ##1 ready)
      else $error("ready not released right after the store");
   AST_RD_READY: assert property (sp && $rose(|hostDataOe) |=> !ready)
      else $error("ready not low after read data shown");
   AST_RD_HOLD: assert property (sp && $fell(|hostDataOe) |-> !ready ##1 ready)
      else $error("ready hold after read wrong");
   AST_ACK_RD: assert property (ds && $rose(|hostDataOe) |=> !transfer_acknowledge_n)
      else $error("acknowledge not low after read data shown");
   AST_ACK_END: assert property (ds && $fell(|hostDataOe) |-> transfer_acknowledge_n)
      else $error("acknowledge not released with the data");
   AST_QUIET: assert property (!hostModeValid || hostMode[1] |-> hostDataOe == 16'h0000)
      else $error("data pins driven outside parallel modes");
   AST_SRC_ADDR: assert property (hostModeValid && hostMode != 2'h3 |-> serialSrcAddr == 8'h00)
      else $error("source address set outside serial select");
   AST_PLL_REG: assert property (hostModeValid && $past(hostModeValid) && !hostMode[1]
      |-> pllDivM == $past(pll_div_m_reg) && pllDivN == $past(pll_div_n_reg))
      else $error("divider not taken from register fields");
   AST_MODE_KEEP: assert property (hostModeValid |=> hostModeValid && $stable(hostMode))
      else $error("captured mode changed");
   AST_LANES: assert property (regWr || regRd |-> regByteEn != 2'h0)
      else $error("register access with no lane");
endmodule
bind async_host_port_strapping async_host_port_monitor i_async_host_port_monitor (
   .clk, .arst_n, .hostDataOe, .ready, .transfer_acknowledge_n, .pll_div_m_reg,
   .pll_div_n_reg, .pllDivM, .pllDivN, .hostMode, .hostModeValid, .serialSrcAddr,
   .regByteEn, .regWr, .regRd);
`default_nettype wire

// file: bench/reg_store_model.sv
// Purpose: Register file behind the port; answers a read one cycle after the strobe.
// Assumes: Word index is the address without bit 0.
// Notes:   Outside the answer cycle read data toggle, so stale data cannot pass.
`timescale 1ns/100ps
`default_nettype none
module reg_store_model (
   input  wire logic        clk,
   input  wire logic [10:0] regAddr,
   input  wire logic [15:0] regWrData,
   input  wire logic [1:0]  regByteEn,
   input  wire logic        regWr,
   input  wire logic        regRd,
   output logic      [15:0] regRdData
);
   logic [15:0] mem [0:1023];
   initial regRdData = 16'h0000;
   always @(posedge clk) begin
      if (regWr && regByteEn[0]) mem[regAddr[10:1]][7:0] <= regWrData[7:0];
      if (regWr && regByteEn[1]) mem[regAddr[10:1]][15:8] <= regWrData[15:8];
      regRdData <= regRd ? mem[regAddr[10:1]] : ~regRdData;
   end
endmodule
`default_nettype wire

// file: bench/tb_async_host_port_strapping.sv
// Purpose: Drives strapping and both parallel styles, checks data and handshakes.
// Assumes: Register store model keeps contents across resets.
// Notes:   Host floats the bus on reads; a toggling pattern shows on undriven pins.
`timescale 1ns/100ps
`default_nettype none
module tb_async_host_port_strapping;
   logic clk, arst_n, selectN, readN, writeN, dataStrobeN, readNotWrite, addrLatchEn;
   logic high_byte_enable_n, low_byte_enable_n, busWide16, ready, transfer_acknowledge_n;
   logic hostModeValid, regWr, regRd, hs;
   logic [1:0]  host_mode_strap, hostMode, regByteEn;
   logic [10:0] hostAddr, regAddr;
   logic [15:0] hostDataIn, hostDataOut, hostDataOe, regWrData, regRdData, hostDrv, r;
   logic [4:0]  pll_div_m_reg, pllDivM;
   logic [5:0]  pll_div_n_reg, pllDivN;
   logic [7:0]  serialSrcAddr;
   int          n_errors, n_compared;
   assign hostDataIn = (hostDataOe & hostDataOut) | (~hostDataOe & hostDrv);
   assign hs = host_mode_strap[0] ? transfer_acknowledge_n : ready;
   async_host_port_strapping i_async_host_port_strapping (.clk, .arst_n, .host_mode_strap,
      .selectN, .readN, .writeN, .dataStrobeN, .readNotWrite, .addrLatchEn,
      .high_byte_enable_n, .low_byte_enable_n, .hostAddr, .hostDataIn, .hostDataOut,
      .hostDataOe, .ready, .transfer_acknowledge_n, .busWide16, .pll_div_m_reg,
      .pll_div_n_reg, .pllDivM, .pllDivN, .hostMode, .hostModeValid, .serialSrcAddr,
      .regAddr, .regWrData, .regByteEn, .regWr, .regRd, .regRdData);
   reg_store_model i_reg_store_model (.clk, .regAddr, .regWrData, .regByteEn, .regWr,
      .regRd, .regRdData);
   task automatic stop_test;
      if (n_errors == 0 && n_compared > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      n_compared++;
      if (got !== exp) begin
         n_errors++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask
   // Straps are changed only together with a fresh hardware reset
   task automatic rst(input logic [1:0] m, input logic [10:0] a, input logic [15:0] d);
      int i;
      @(posedge clk);
      host_mode_strap <= m;
      hostAddr <= a;
      hostDrv <= d;
      arst_n <= 1'b0;
      repeat (5) @(posedge clk);
      arst_n <= 1'b1;
      for (i = 0; i < 20 && hostModeValid !== 1'b1; i++) begin @(posedge clk); #1; end
      repeat (2) @(posedge clk);
      #1;
      chk("mode", {14'h0, m}, {14'h0, hostMode});
   endtask
   task automatic acc(input logic wr, input logic [10:0] a, input logic be,
                      input logic [15:0] wd, output logic [15:0] rd);
      int i;
      @(posedge clk);
      hostAddr <= a;
      hostDrv <= wr ? wd : ~hostDrv;
      high_byte_enable_n <= be;
      low_byte_enable_n <= be;
      readNotWrite <= !wr;
      selectN <= 1'b0;
      if (host_mode_strap[0]) dataStrobeN <= 1'b0;
      else if (wr) writeN <= 1'b0;
      else readN <= 1'b0;
      for (i = 0; i < 40 && hs !== 1'b0; i++) begin @(posedge clk); #1; end
      chk("handshake low", 16'h0000, {15'h0, hs});
      rd = hostDataIn & hostDataOe;
      @(posedge clk);
      {selectN, readN, writeN, dataStrobeN} <= 4'hF;
      for (i = 0; i < 40 && hs !== 1'b1; i++) begin @(posedge clk); #1; end
      chk("handshake high", 16'h0001, {15'h0, hs});
   endtask
   task automatic sc_strobe_pair;
      rst(2'h0, 11'h000, 16'h0000);
      chk("pll m", 16'h0003, {11'h0, pllDivM});
      chk("pll n", 16'h0007, {10'h0, pllDivN});
      acc(1'b1, 11'h010, 1'b0, 16'h1234, r);
      acc(1'b1, 11'h011, 1'b0, 16'hAB00, r);
      acc(1'b1, 11'h011, 1'b1, 16'hFFFF, r);
      acc(1'b0, 11'h010, 1'b0, 16'h0000, r);
      chk("word", 16'hAB34, r);
      acc(1'b0, 11'h010, 1'b1, 16'h0000, r);
      chk("even byte", 16'h0034, r);
      acc(1'b0, 11'h011, 1'b0, 16'h0000, r);
      chk("odd byte", 16'hAB00, r);
      acc(1'b0, 11'h011, 1'b1, 16'h0000, r);
      chk("no transfer", 16'h0000, r);
      acc(1'b1, 11'h7FE, 1'b0, 16'h5A5A, r);
      chk("top address", 16'h07FE, {5'h0, regAddr});
      @(posedge clk);
      busWide16 <= 1'b0;
      acc(1'b0, 11'h011, 1'b0, 16'h0000, r);
      chk("narrow odd", 16'h00AB, r);
      acc(1'b1, 11'h7FF, 1'b0, 16'h00CD, r);
      acc(1'b0, 11'h7FF, 1'b0, 16'h0000, r);
      chk("narrow write", 16'h00CD, r);
      @(posedge clk);
      busWide16 <= 1'b1;
   endtask
   task automatic sc_data_strobe;
      rst(2'h1, 11'h000, 16'h0000);
      acc(1'b1, 11'h020, 1'b0, 16'h1234, r);
      acc(1'b0, 11'h021, 1'b0, 16'h0000, r);
      chk("odd lower", 16'h0034, r);
      acc(1'b0, 11'h020, 1'b1, 16'h0000, r);
      chk("even upper", 16'h1200, r);
      // A moving latch enable must not make the data-strobe bus multiplexed
      @(posedge clk);
      hostDrv <= 16'h0010;
      addrLatchEn <= 1'b1;
      @(posedge clk);
      addrLatchEn <= 1'b0;
      repeat (4) @(posedge clk);
      acc(1'b0, 11'h020, 1'b0, 16'h0000, r);
      chk("word", 16'h1234, r);
      acc(1'b0, 11'h021, 1'b1, 16'h0000, r);
      chk("no transfer", 16'h0000, r);
   endtask
   task automatic sc_serial;
      for (int m = 2; m < 4; m++) begin
         rst(m[1:0], 11'h02D, 16'hAD40);
         chk("source", (m == 3) ? 16'h00B6 : 16'h0000, {8'h0, serialSrcAddr});
         chk("pll m", 16'h0015, {11'h0, pllDivM});
         chk("pll n", 16'h002A, {10'h0, pllDivN});
      end
   endtask
   task automatic sc_mux;
      rst(2'h0, 11'h000, 16'h0000);
      @(posedge clk);
      hostDrv <= 16'h0010;
      addrLatchEn <= 1'b1;
      @(posedge clk);
      addrLatchEn <= 1'b0;
      repeat (4) @(posedge clk);
      acc(1'b0, 11'h7FE, 1'b0, 16'h0000, r);
      chk("latched data", 16'hAB34, r);
      chk("latched address", 16'h0010, {5'h0, regAddr});
   endtask
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   initial begin
      #250000;
      n_errors++;
      stop_test();
   end
   initial begin
      n_errors = 0;
      n_compared = 0;
      arst_n = 1'b0;
      host_mode_strap = 2'h0;
      {selectN, readN, writeN, dataStrobeN, readNotWrite} = 5'h1F;
      {addrLatchEn, high_byte_enable_n, low_byte_enable_n} = 3'h0;
      busWide16 = 1'b1;
      hostAddr = 11'h000;
      hostDrv = 16'h0000;
      pll_div_m_reg = 5'h03;
      pll_div_n_reg = 6'h07;
      sc_strobe_pair();
      sc_data_strobe();
      sc_serial();
      sc_mux();
      stop_test();
   end
endmodule
`default_nettype wire
